// file: core/spdg_pkg.sv
// Purpose: Shared constants and types for the signal path and digital gain block
// Assumes: One clock, synchronous reset
// Notes:   All configuration arrives on plain ports
package spdg_pkg;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int unsigned SPDG_NUM_AIN = 10;
   localparam int unsigned SPDG_NUM_BIAS_AIN = 8;
   localparam int unsigned SPDG_AIN_SEL_W = 4;
   localparam int unsigned SPDG_MOD_W = 32;
   localparam int unsigned SPDG_CONV_W = 24;
   localparam int unsigned SPDG_GAIN_W = 3;
   localparam int unsigned SPDG_SHIFT_W = 2;
   localparam int unsigned SPDG_DEC_W = 2;

   // ----------------------------------------
   // Field values and counts
   // ----------------------------------------
   localparam logic [SPDG_SHIFT_W-1:0] SPDG_SHIFT_X1 = 2'h0;
   localparam logic [SPDG_SHIFT_W-1:0] SPDG_SHIFT_X2 = 2'h1;
   localparam logic [SPDG_SHIFT_W-1:0] SPDG_SHIFT_X4 = 2'h2;
   localparam logic [SPDG_GAIN_W-1:0] SPDG_GAIN_X1 = 3'h0;
   localparam logic [SPDG_GAIN_W-1:0] SPDG_GAIN_X2 = 3'h1;
   localparam logic [SPDG_DEC_W-1:0] SPDG_QUARTER_LAST = 2'h3;
   localparam logic [SPDG_NUM_AIN-1:0] SPDG_BIAS_ALLOWED = 10'h0ff;
   localparam logic [SPDG_CONV_W-1:0] SPDG_CONV_RST = 24'h000000;
   localparam logic [SPDG_GAIN_W-1:0] SPDG_AMP_GAIN_RST = 3'h0;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      SPDG_PATH_BYPASS = 2'b00,
      SPDG_PATH_BUFFER = 2'b01,
      SPDG_PATH_AMP    = 2'b10,
      SPDG_PATH_RSVD   = 2'b11
   } spdg_path_mode_t;

   typedef struct packed {
      spdg_path_mode_t mode;
      logic [SPDG_GAIN_W-1:0] gain;
      logic unipolar;
      logic fourth_order_sinc_filter;
      logic single_cycle;
   } spdg_cfg_t;

   typedef struct packed {
      logic src_a_en;
      logic [SPDG_AIN_SEL_W-1:0] src_a_sel;
      logic src_b_en;
      logic [SPDG_AIN_SEL_W-1:0] src_b_sel;
      logic [SPDG_NUM_AIN-1:0] bias_req;
   } spdg_route_t;

   typedef struct packed {
      logic [SPDG_NUM_AIN-1:0] excitation_current_source_a;
      logic [SPDG_NUM_AIN-1:0] excitation_current_source_b;
      logic [SPDG_NUM_AIN-1:0] bias_conn;
   } spdg_pins_t;

   typedef struct packed {
      logic direct_conn;
      logic buf_en;
      logic amp_en;
      logic [SPDG_GAIN_W-1:0] amp_gain;
   } spdg_analog_t;

endpackage : spdg_pkg

// file: core/spdg_route.sv
// Purpose: Decode current source and bias routing onto analog input pins
// Assumes: Inputs are registered by the caller
// Notes:   Pure combinational, three switches per pin
`timescale 1ns/10ps
`default_nettype none

module spdg_route (
   input wire spdg_pkg::spdg_route_t route,
   output spdg_pkg::spdg_pins_t pins
);
   import spdg_pkg::*;

   // ----------------------------------------
   // Per-pin switch decode
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < SPDG_NUM_AIN; i = i + 1) begin : g_pin
         assign pins.excitation_current_source_a[i] =
            route.src_a_en && (route.src_a_sel == SPDG_AIN_SEL_W'(i));
         assign pins.excitation_current_source_b[i] =
            route.src_b_en && (route.src_b_sel == SPDG_AIN_SEL_W'(i));
         assign pins.bias_conn[i] = route.bias_req[i] && SPDG_BIAS_ALLOWED[i];
      end
   endgenerate

endmodule : spdg_route

`default_nettype wire

// file: core/spdg_scale.sv
// Purpose: Scale a 32-bit modulator word to a 24-bit conversion word
// Assumes: Shift already limited to x1, x2 or x4
// Notes:   Combinational; caller registers the result
`timescale 1ns/10ps
`default_nettype none

module spdg_scale (
   input wire logic [spdg_pkg::SPDG_MOD_W-1:0] mod_word,
   input wire logic [spdg_pkg::SPDG_SHIFT_W-1:0] shift,
   input wire logic unipolar,
   output logic [spdg_pkg::SPDG_CONV_W-1:0] conv_word,
   output logic overflow
);
   import spdg_pkg::*;

   logic [SPDG_CONV_W-1:0] sel_word;

   // ----------------------------------------
   // Bit window select
   // ----------------------------------------
   always_comb begin
      case (shift)
         SPDG_SHIFT_X2: begin
            sel_word = mod_word[30:7];
            overflow = mod_word[31] != mod_word[30];
         end
         SPDG_SHIFT_X4: begin
            sel_word = mod_word[29:6];
            overflow = (mod_word[31] != mod_word[29]) || (mod_word[30] != mod_word[29]);
         end
         default: begin
            sel_word = mod_word[31:8];
            overflow = 1'b0;
         end
      endcase
   end

   // ----------------------------------------
   // Code span
   // ----------------------------------------
   // Unipolar floor at zero
   always_comb begin
      if (unipolar && sel_word[SPDG_CONV_W-1]) begin
         conv_word = SPDG_CONV_RST;
      end else begin
         conv_word = sel_word;
      end
   end

endmodule : spdg_scale

`default_nettype wire

// file: core/spdg_top.sv
// Purpose: Signal path selection, input routing and digital gain datapath
// Assumes: Configuration and modulator words come from logic on mclk
// Notes:   Configuration is sampled every cycle; a change restarts the
//          single-cycle decimation phase
//          Words need cfg steady two cycles; the shift lags cfg_q
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Either current source reaches any input pin
// - Bias voltage reaches inputs zero to seven
// - Mode field picks bypass, buffer or amplifier
// - Bypass: direct path, buffers and amplifier off
// - Buffered: buffers drive modulator, amplifier off
// - Amplifier mode: amplifier in path, buffers off
// - Amplifier gains one through 128, powers two
// - Bypass or buffered: digital gain 1, 2, 4
// - Requested gain four or more gives four
// - Unity gain drops eight low bits
// - Gain two drops MSB and seven LSBs
// - Fourth-order sinc single-cycle: quarter rate
// - Code spans zero or plus-minus full scale
module spdg_top (
   input wire logic mclk,
   input wire logic rst,
   input wire spdg_pkg::spdg_cfg_t cfg,
   input wire spdg_pkg::spdg_route_t route,
   input wire logic mod_valid,
   input wire logic [spdg_pkg::SPDG_MOD_W-1:0] mod_data,
   output spdg_pkg::spdg_pins_t pins,
   output spdg_pkg::spdg_analog_t analog,
   output logic [spdg_pkg::SPDG_GAIN_W-1:0] digital_gain_code,
   output logic conv_valid,
   output logic [spdg_pkg::SPDG_CONV_W-1:0] conv_data,
   output logic conv_overflow,
   output logic conv_unipolar
);
   import spdg_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   spdg_cfg_t cfg_q;
   spdg_route_t route_q;
   spdg_pins_t pins_d;
   spdg_pins_t pins_q;
   spdg_analog_t analog_d;
   spdg_analog_t analog_q;
   spdg_path_mode_t mode_eff;
   logic [SPDG_SHIFT_W-1:0] shift_d;
   logic [SPDG_SHIFT_W-1:0] shift_q;
   logic [SPDG_GAIN_W-1:0] dgain_d;
   logic [SPDG_GAIN_W-1:0] dgain_q;
   logic [SPDG_DEC_W-1:0] dec_cnt_q;
   logic [SPDG_DEC_W-1:0] dec_cnt_d;
   logic quarter_rate;
   logic cfg_change;
   logic take_word;
   logic [SPDG_CONV_W-1:0] scaled_word;
   logic scaled_ovf;
   logic conv_valid_q;
   logic [SPDG_CONV_W-1:0] conv_data_q;
   logic conv_overflow_q;
   logic conv_unipolar_q;

   // ----------------------------------------
   // Configuration capture
   // ----------------------------------------
   // Held copies keep the analog switches glitch-free between edges
   always_ff @(posedge mclk) begin
      if (rst) begin
         cfg_q <= '0;
      end else begin
         cfg_q <= cfg;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         route_q <= '0;
      end else begin
         route_q <= route;
      end
   end

   // Any field change counts, so a polarity flip drops a word too
   assign cfg_change = (cfg_q != cfg);

   // ----------------------------------------
   // Pin routing
   // ----------------------------------------
   spdg_route u_route (
      .route (route_q),
      .pins  (pins_d)
   );

   always_ff @(posedge mclk) begin
      if (rst) begin
         pins_q <= '0;
      end else begin
         pins_q <= pins_d;
      end
   end

   assign pins = pins_q;

   // ----------------------------------------
   // Signal path mode
   // ----------------------------------------
   // Reserved code falls back to the lowest-power path
   // Three path options
   always_comb begin
      case (cfg_q.mode)
         SPDG_PATH_BUFFER: mode_eff = SPDG_PATH_BUFFER;
         SPDG_PATH_AMP: mode_eff = SPDG_PATH_AMP;
         default: mode_eff = SPDG_PATH_BYPASS;
      endcase
   end

   always_comb begin
      analog_d = '0;
      case (mode_eff)
         SPDG_PATH_BUFFER: begin
            analog_d.direct_conn = 1'b0;
            analog_d.buf_en = 1'b1;
            analog_d.amp_en = 1'b0;
            analog_d.amp_gain = SPDG_AMP_GAIN_RST;
         end
         SPDG_PATH_AMP: begin
            analog_d.direct_conn = 1'b0;
            analog_d.buf_en = 1'b0;
            analog_d.amp_en = 1'b1;
            analog_d.amp_gain = cfg_q.gain;
         end
         default: begin
            analog_d.direct_conn = 1'b1;
            analog_d.buf_en = 1'b0;
            analog_d.amp_en = 1'b0;
            analog_d.amp_gain = SPDG_AMP_GAIN_RST;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         analog_q <= '0;
         analog_q.direct_conn <= 1'b1;
      end else begin
         analog_q <= analog_d;
      end
   end

   assign analog = analog_q;

   // ----------------------------------------
   // Digital gain selection
   // ----------------------------------------
   // Amplifier mode gains in the analog domain only, so digital stays x1
   always_comb begin
      if (mode_eff == SPDG_PATH_AMP) begin
         shift_d = SPDG_SHIFT_X1;
      end else if (cfg_q.gain == SPDG_GAIN_X1) begin
         shift_d = SPDG_SHIFT_X1;
      end else if (cfg_q.gain == SPDG_GAIN_X2) begin
         shift_d = SPDG_SHIFT_X2;
      end else begin
         shift_d = SPDG_SHIFT_X4;
      end
   end

   // Status code follows the shift, so the two never disagree
   always_comb begin
      case (shift_d)
         SPDG_SHIFT_X2: dgain_d = SPDG_GAIN_X2;
         SPDG_SHIFT_X4: dgain_d = {1'b0, SPDG_SHIFT_X4};
         default: dgain_d = SPDG_GAIN_X1;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         shift_q <= SPDG_SHIFT_X1;
      end else begin
         shift_q <= shift_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         dgain_q <= SPDG_GAIN_X1;
      end else begin
         dgain_q <= dgain_d;
      end
   end

   assign digital_gain_code = dgain_q;

   // ----------------------------------------
   // Output rate decimation
   // ----------------------------------------
   // Single-cycle fourth-order sinc quarter
   assign quarter_rate = cfg_q.fourth_order_sinc_filter && cfg_q.single_cycle;

   always_comb begin
      dec_cnt_d = dec_cnt_q;
      if (cfg_change) begin
         dec_cnt_d = '0;
      end else if (mod_valid && quarter_rate) begin
         // Wrap explicitly rather than lean on the 2-bit rollover
         if (dec_cnt_q == SPDG_QUARTER_LAST) begin
            dec_cnt_d = '0;
         end else begin
            dec_cnt_d = dec_cnt_q + 2'h1;
         end
      end
   end

   // Restart on reconfiguration so a stale phase never leaks a sample
   always_ff @(posedge mclk) begin
      if (rst) begin
         dec_cnt_q <= '0;
      end else begin
         dec_cnt_q <= dec_cnt_d;
      end
   end

   always_comb begin
      take_word = 1'b0;
      if (mod_valid && !cfg_change) begin
         if (!quarter_rate) begin
            take_word = 1'b1;
         end else if (dec_cnt_q == SPDG_QUARTER_LAST) begin
            take_word = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Scaling datapath
   // ----------------------------------------
   // Shift lags cfg_q by one edge; a word sent too soon after
   // a gain change is scaled with the old gain
   spdg_scale u_scale (
      .mod_word  (mod_data),
      .shift     (shift_q),
      .unipolar  (cfg_q.unipolar),
      .conv_word (scaled_word),
      .overflow  (scaled_ovf)
   );

   always_ff @(posedge mclk) begin
      if (rst) begin
         conv_data_q <= SPDG_CONV_RST;
      end else if (take_word) begin
         conv_data_q <= scaled_word;
      end
   end

   // Overflow travels with its word; discarded MSBs lost information
   always_ff @(posedge mclk) begin
      if (rst) begin
         conv_overflow_q <= 1'b0;
      end else if (take_word) begin
         conv_overflow_q <= scaled_ovf;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         conv_unipolar_q <= 1'b0;
      end else if (take_word) begin
         conv_unipolar_q <= cfg_q.unipolar;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         conv_valid_q <= 1'b0;
      end else begin
         conv_valid_q <= take_word;
      end
   end

   assign conv_valid = conv_valid_q;
   assign conv_data = conv_data_q;
   assign conv_overflow = conv_overflow_q;
   assign conv_unipolar = conv_unipolar_q;

endmodule : spdg_top

`default_nettype wire

// file: verification/spdg_top_chk.sv
// Purpose: Port-level checks for spdg_top
// Assumes: Single mclk domain, synchronous rst
// Notes:   Routing, path and gain checks wait two clean edges after reset
`timescale 1ns/10ps
`default_nettype none

module spdg_top_chk
   import spdg_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire spdg_cfg_t cfg,
   input wire spdg_route_t route,
   input wire logic mod_valid,
   input wire logic [SPDG_MOD_W-1:0] mod_data,
   input wire spdg_pins_t pins,
   input wire spdg_analog_t analog,
   input wire logic [SPDG_GAIN_W-1:0] digital_gain_code,
   input wire logic conv_valid,
   input wire logic [SPDG_CONV_W-1:0] conv_data,
   input wire logic conv_unipolar
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic q_mode;
   assign q_mode = cfg.fourth_order_sinc_filter && cfg.single_cycle;
   // Outputs lag config by two edges
   sequence s_settled;
      !$past(rst) && !$past(rst, 2);
   endsequence
   sequence s_mode(logic [1:0] m);
      s_settled ##0 $past(cfg.mode, 2) == m;
   endsequence
   sequence s_kept_q;
      conv_valid && q_mode ##1 q_mode [*3];
   endsequence
   property p_src_a;
      s_settled |-> pins.excitation_current_source_a == (($past(route.src_a_en, 2) &&
         $past(route.src_a_sel, 2) < 10) ? 10'h1 << $past(route.src_a_sel, 2) : 10'h0);
   endproperty
   a_src_a: assert property (p_src_a) else $error("source a routing wrong");
   property p_bias;
      s_settled |-> pins.bias_conn == ($past(route.bias_req, 2) & 10'h0ff);
   endproperty
   a_bias: assert property (p_bias) else $error("bias routing wrong");
   property p_bypass;
      s_mode(2'h0) or s_mode(2'h3) |-> analog == 6'h20;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass path wrong");
   property p_buffer;
      s_mode(2'h1) |-> analog == 6'h10;
   endproperty
   a_buffer: assert property (p_buffer) else $error("buffer path wrong");
   property p_amp;
      s_mode(2'h2) |-> analog == {3'h1, $past(cfg.gain, 2)};
   endproperty
   a_amp: assert property (p_amp) else $error("amplifier path wrong");
   property p_dgain;
      s_settled ##0 $past(cfg.mode, 2) != SPDG_PATH_AMP |->
         digital_gain_code == ($past(cfg.gain, 2) >= 3'h2 ? 3'h2 : $past(cfg.gain, 2));
   endproperty
   a_dgain: assert property (p_dgain) else $error("digital gain wrong");
   property p_unity;
      conv_valid && $past(cfg.mode) == SPDG_PATH_AMP && $past(cfg, 3) == $past(cfg) &&
         !$past(cfg.unipolar) |-> conv_data == 24'($past(mod_data) >> 8);
   endproperty
   a_unity: assert property (p_unity) else $error("unity scaling wrong");
   property p_lat;
      !$past(rst) && mod_valid && $stable(cfg) && !q_mode |=> conv_valid;
   endproperty
   a_lat: assert property (p_lat) else $error("word not converted");
   property p_quarter;
      s_kept_q |-> !conv_valid && !$past(conv_valid) && !$past(conv_valid, 2);
   endproperty
   a_quarter: assert property (p_quarter) else $error("quarter rate broken");
   property p_uni;
      conv_valid |-> conv_unipolar == $past(cfg.unipolar) && !(conv_unipolar && conv_data[23]);
   endproperty
   a_uni: assert property (p_uni) else $error("polarity code wrong");
endmodule : spdg_top_chk

bind spdg_top spdg_top_chk chk (.mclk, .rst, .cfg, .route, .mod_valid, .mod_data, .pins, .analog,
   .digital_gain_code, .conv_valid, .conv_data, .conv_unipolar);

`default_nettype wire

// file: verification/spdg_mod_src.sv
// Purpose: Modulator word source standing in for the sensor path
// Assumes: Seeded by the bench before go rises
// Notes:   Idle data toggles so stale words never look valid
`timescale 1ns/10ps
`default_nettype none

module spdg_mod_src (
   input wire logic mclk,
   input wire logic go,
   input wire logic slow,
   output logic mod_valid,
   output logic [spdg_pkg::SPDG_MOD_W-1:0] mod_data
);
   initial mod_valid = 1'b0;
   initial mod_data = '0;
   // Slow mode leaves a gap after each word
   always @(posedge mclk) begin
      if (go && !(slow && mod_valid)) begin
         mod_valid <= 1'b1;
         mod_data <= $urandom;
      end else begin
         mod_valid <= 1'b0;
         mod_data <= ~mod_data;
      end
   end
endmodule : spdg_mod_src

`default_nettype wire

// file: verification/spdg_top_tb.sv
// Purpose: Self-checking bench for spdg_top
// Assumes: Words only after a gain change settles two cycles
// Notes:   Reference model runs at negedge on queued inputs
`timescale 1ns/10ps
`default_nettype none

module spdg_top_tb;
   import spdg_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic go = 1'b0;
   logic slow = 1'b0;
   spdg_cfg_t cfg = '0;
   spdg_route_t route = '0;
   logic mod_valid;
   logic [SPDG_MOD_W-1:0] mod_data;
   spdg_pins_t pins;
   spdg_analog_t analog;
   logic [SPDG_GAIN_W-1:0] digital_gain_code;
   logic conv_valid;
   logic [SPDG_CONV_W-1:0] conv_data;
   logic conv_overflow;
   logic conv_unipolar;
   int n_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int cnt = 0;
   int s;
   logic exp_v = 1'b0;
   logic [SPDG_CONV_W-1:0] exp_d = '0;
   logic exp_o = 1'b0;
   int top_bits;
   spdg_cfg_t cfg_prev = '0;
   spdg_cfg_t s_list[2] = '{8'h0b, 8'h14};

   always #5 mclk = ~mclk;

   spdg_top DUT (.mclk, .rst, .cfg, .route, .mod_valid, .mod_data, .pins, .analog,
      .digital_gain_code, .conv_valid, .conv_data, .conv_overflow, .conv_unipolar);
   spdg_mod_src src (.mclk, .go, .slow, .mod_valid, .mod_data);

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk

   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test

   task automatic setcfg(input spdg_cfg_t c);
      go <= 1'b0;
      cfg <= c;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
   endtask : setcfg

   function automatic spdg_pins_t pexp(input spdg_route_t r);
      pexp = '0;
      if (r.src_a_en && r.src_a_sel < 10) pexp.excitation_current_source_a[r.src_a_sel] = 1'b1;
      if (r.src_b_en && r.src_b_sel < 10) pexp.excitation_current_source_b[r.src_b_sel] = 1'b1;
      pexp.bias_conn = r.bias_req & 10'h0ff;
   endfunction : pexp

   // ----------------------------------------
   // Reference model and timeout
   // ----------------------------------------
   always @(negedge mclk) begin
      chk(conv_valid, exp_v);
      if (exp_v) chk(conv_data, exp_d);
      if (exp_v) chk(conv_overflow, exp_o);
      s = (cfg.mode == SPDG_PATH_AMP) ? 0 : (cfg.gain >= 2 ? 2 : int'(cfg.gain));
      exp_v = 1'b0;
      // Config change drops the word and restarts decimation
      if (rst || cfg !== cfg_prev) cnt = 0;
      else if (mod_valid && cfg.fourth_order_sinc_filter && cfg.single_cycle) begin
         exp_v = (cnt == 3);
         cnt = (cnt + 1) % 4;
      end else exp_v = mod_valid;
      exp_d = 24'(mod_data >> (8 - s));
      // Discarded top bits must all copy the kept sign bit
      top_bits = $signed(mod_data) >>> (31 - s);
      exp_o = (top_bits != 0) && (top_bits != -1);
      if (cfg.unipolar && exp_d[23]) exp_d = '0;
      cfg_prev = cfg;
   end

   always @(posedge mclk) begin
      cyc++;
      if (cyc > 3000) begin
         n_errors++;
         stop_test();
      end
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      void'($urandom(96764));
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      for (int m = 0; m < 4; m++) begin
         for (int g = 0; g < 8; g++) begin
            setcfg({m[1:0], g[2:0], g[0], 2'b00});
            chk(digital_gain_code, m == 2 ? 0 : (g >= 2 ? 2 : g));
            chk(analog, m == 2 ? {3'h1, g[2:0]} : (m == 1 ? 6'h10 : 6'h20));
            @(posedge mclk);
            slow <= g[1];
            go <= 1'b1;
            repeat (12) @(posedge mclk);
         end
      end
      for (int i = 0; i < 24; i++) begin
         route <= 20'($urandom);
         repeat (2) @(posedge mclk);
         @(negedge mclk);
         chk(pins, pexp(route));
         @(posedge mclk);
      end
      // Quarter rate, then plain x4 unipolar; flips keep the shift
      foreach (s_list[k]) begin
         setcfg(s_list[k]);
         @(posedge mclk);
         slow <= 1'b0;
         go <= 1'b1;
         repeat (30) @(posedge mclk);
         for (int i = 0; i < 4; i++) begin
            cfg <= cfg ^ 8'h04;
            repeat (7) @(posedge mclk);
         end
      end
      go <= 1'b0;
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      setcfg(8'h80);
      @(posedge mclk);
      go <= 1'b1;
      repeat (10) @(posedge mclk);
      stop_test();
   end
endmodule : spdg_top_tb

`default_nettype wire
